// File: hdl/frwes_sequencer.sv
// Flash row erase and write sequencer with its register file and write latches.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Running code erases only whole rows.
// - Go is followed by two setup cycles.
// - Row erase stalls execution about 2 ms.
// - After stall, execution resumes third instruction.
// - Programming never erases words first.
// - One program writes at most 32 words.
// - Address bits 14:5 row, 4:0 latch.
// - A write never crosses a row boundary.
// - Latches return blank after write or erase.
// - Latch-only go loads addressed latch only.
// - Otherwise, unless erase is selected, go loads latch, programs whole row.
// - Only an unbroken unlock starts anything.
// - Latch loading stalls only two cycles.
// - Row program stalls until write completes.
// - Hardware clears go; software only sets it.
// - Enable clear at power-up, gates operations.
// - Reset during erase or write sets error.
// - Unlock register reads back zero.
module frwes_sequencer #(
    parameter int unsigned OP_CYCLES = `FRWES_OP_TIME_NS / `FRWES_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sysResetReq,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cpuStall,
    output logic nopForce,
    output logic flashErase,
    output logic flashProgram,
    output logic [`FRWES_ROW_W-1:0] flashRowAddr,
    output logic [`FRWES_NUM_LATCHES*`FRWES_DATA_W-1:0] flashRowData
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Bus slave and write latches.

    frwes_pkg::frwes_seq_state_t s;
    frwes_pkg::frwes_seq_state_t next_s;
    logic regWr;
    logic [2:0] regIdx;
    logic [7:0] regData;
    logic rdPulse;
    logic [2:0] rdIdx;
    logic [7:0] rdData;
    logic goRequest;
    logic goAllowed;

    frwes_axil_slave u_bus (
        .clk(clk),
        .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .regWr(regWr),
        .regIdx(regIdx),
        .regData(regData),
        .rdPulse(rdPulse),
        .rdIdx(rdIdx),
        .rdData(rdData)
    );

    frwes_latch_bank u_latches (
        .clk(clk),
        .rstn(rstn),
        .clearAll(s.latchClear),
        .loadEn(s.latchLoad),
        .loadIdx(s.loadIdx),
        .loadData(s.loadData),
        .latchWords(flashRowData)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Register read data.

    always_comb begin
        rdData = 8'h0;
        unique case (rdIdx)
            `FRWES_OFF_ADDR_LOW: begin
                rdData = s.addr[7:0];
            end
            `FRWES_OFF_ADDR_HIGH: begin
                rdData = `FRWES_ADDR_HIGH_FILL | {1'b0, s.addr[14:8]};
            end
            `FRWES_OFF_DATA_LOW: begin
                rdData = s.data[7:0];
            end
            `FRWES_OFF_DATA_HIGH: begin
                rdData = {2'h0, s.data[13:8]};
            end
            `FRWES_OFF_CONTROL: begin
                rdData[`FRWES_CTRL_FILL] = 1'b1;
                rdData[`FRWES_CTRL_CONFIG_SPACE_SELECT] = s.config_space_select;
                rdData[`FRWES_CTRL_LATCH_ONLY] = s.latch_only;
                rdData[`FRWES_CTRL_ERASE] = s.eraseSel;
                rdData[`FRWES_CTRL_ERR] = s.errFlag;
                rdData[`FRWES_CTRL_PROGRAM_ENABLE] = s.program_enable;
                rdData[`FRWES_CTRL_GO] = s.go;
            end
            default: begin
                rdData = 8'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Go request qualification.

    always_comb begin
        goRequest = regWr && (regIdx == `FRWES_OFF_CONTROL) && regData[`FRWES_CTRL_GO] && !s.go;
        goAllowed = (s.unlock == frwes_pkg::UNL_ARMED) && s.program_enable && !s.config_space_select;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Sequencer next state.

    always_comb begin
        next_s = s;
        next_s.latchLoad = 1'b0;
        next_s.latchClear = 1'b0;
        next_s.abortSync1 = sysResetReq;
        next_s.abortSync2 = s.abortSync1;

        if (regWr) begin
            unique case (regIdx)
                `FRWES_OFF_ADDR_LOW: begin
                    next_s.addr[7:0] = regData;
                end
                `FRWES_OFF_ADDR_HIGH: begin
                    next_s.addr[14:8] = regData[6:0];
                end
                `FRWES_OFF_DATA_LOW: begin
                    next_s.data[7:0] = regData;
                end
                `FRWES_OFF_DATA_HIGH: begin
                    next_s.data[13:8] = regData[5:0];
                end
                `FRWES_OFF_CONTROL: begin
                    if (s.seq == frwes_pkg::SEQ_IDLE) begin
                        next_s.config_space_select = regData[`FRWES_CTRL_CONFIG_SPACE_SELECT];
                        next_s.latch_only = regData[`FRWES_CTRL_LATCH_ONLY];
                        next_s.eraseSel = regData[`FRWES_CTRL_ERASE];
                        next_s.program_enable = regData[`FRWES_CTRL_PROGRAM_ENABLE];
                        next_s.errFlag = regData[`FRWES_CTRL_ERR];
                    end
                end
                default: begin
                end
            endcase
            if (regIdx == `FRWES_OFF_UNLOCK && regData == `FRWES_UNLOCK_KEY1) begin
                next_s.unlock = frwes_pkg::UNL_KEY1;
            end else if (regIdx == `FRWES_OFF_UNLOCK && regData == `FRWES_UNLOCK_KEY2
                         && s.unlock == frwes_pkg::UNL_KEY1) begin
                next_s.unlock = frwes_pkg::UNL_ARMED;
            end else begin
                next_s.unlock = frwes_pkg::UNL_IDLE;
            end
        end else if (rdPulse) begin
            next_s.unlock = frwes_pkg::UNL_IDLE;
        end

        if (goRequest && s.seq == frwes_pkg::SEQ_IDLE) begin
            if (goAllowed) begin
                next_s.go = 1'b1;
                next_s.seq = frwes_pkg::SEQ_SETUP;
                next_s.cpuStall = 1'b1;
                next_s.nopForce = 1'b1;
                next_s.count = `FRWES_SETUP_CYCLES - 32'h1;
                next_s.rowAddr = s.addr[14:5];
                if (s.eraseSel) begin
                    next_s.op = frwes_pkg::OP_ERASE;
                end else begin
                    next_s.latchLoad = 1'b1;
                    next_s.loadIdx = s.addr[4:0];
                    next_s.loadData = s.data;
                    next_s.op = s.latch_only ? frwes_pkg::OP_LATCH : frwes_pkg::OP_PROGRAM;
                end
            end else begin
                next_s.errFlag = 1'b1;
            end
        end

        unique case (s.seq)
            frwes_pkg::SEQ_IDLE: begin
            end
            frwes_pkg::SEQ_SETUP: begin
                next_s.count = s.count - 32'h1;
                if (s.count == 32'h0) begin
                    next_s.nopForce = 1'b0;
                    if (s.op == frwes_pkg::OP_LATCH) begin
                        next_s.seq = frwes_pkg::SEQ_IDLE;
                        next_s.cpuStall = 1'b0;
                        next_s.go = 1'b0;
                    end else begin
                        next_s.seq = frwes_pkg::SEQ_BUSY;
                        next_s.count = 32'(OP_CYCLES - 1);
                        next_s.flashErase = (s.op == frwes_pkg::OP_ERASE);
                        next_s.flashProgram = (s.op == frwes_pkg::OP_PROGRAM);
                    end
                end
            end
            frwes_pkg::SEQ_BUSY: begin
                next_s.count = s.count - 32'h1;
                if (s.count == 32'h0) begin
                    next_s.seq = frwes_pkg::SEQ_IDLE;
                    next_s.cpuStall = 1'b0;
                    next_s.flashErase = 1'b0;
                    next_s.flashProgram = 1'b0;
                    next_s.latchClear = 1'b1;
                    next_s.go = 1'b0;
                    if (s.op == frwes_pkg::OP_ERASE) begin
                        next_s.eraseSel = 1'b0;
                    end
                end
            end
            default: begin
                next_s.seq = frwes_pkg::SEQ_IDLE;
            end
        endcase

        if (s.abortSync2) begin
            if (s.seq != frwes_pkg::SEQ_IDLE && s.op != frwes_pkg::OP_LATCH) begin
                next_s.errFlag = 1'b1;
            end
            next_s.seq = frwes_pkg::SEQ_IDLE;
            next_s.go = 1'b0;
            next_s.cpuStall = 1'b0;
            next_s.nopForce = 1'b0;
            next_s.flashErase = 1'b0;
            next_s.flashProgram = 1'b0;
            next_s.latchLoad = 1'b0;
            next_s.latchClear = 1'b1;
            next_s.unlock = frwes_pkg::UNL_IDLE;
            next_s.addr = '0;
            next_s.config_space_select = 1'b0;
            next_s.latch_only = 1'b0;
            next_s.eraseSel = 1'b0;
            next_s.program_enable = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign cpuStall = s.cpuStall;
    assign nopForce = s.nopForce;
    assign flashErase = s.flashErase;
    assign flashProgram = s.flashProgram;
    assign flashRowAddr = s.rowAddr;

endmodule : frwes_sequencer

`default_nettype wire

// File: hdl/frwes_cfg.svh
// Offsets, field positions, reset values and timing counts of the flash sequencer.
`ifndef FRWES_CFG_SVH
`define FRWES_CFG_SVH

`define FRWES_OFF_ADDR_LOW 3'h0
`define FRWES_OFF_ADDR_HIGH 3'h1
`define FRWES_OFF_DATA_LOW 3'h2
`define FRWES_OFF_DATA_HIGH 3'h3
`define FRWES_OFF_CONTROL 3'h4
`define FRWES_OFF_UNLOCK 3'h5
`define FRWES_NUM_REGS 3'h6

`define FRWES_CTRL_FILL 7
`define FRWES_CTRL_CONFIG_SPACE_SELECT 6
`define FRWES_CTRL_LATCH_ONLY 5
`define FRWES_CTRL_ERASE 4
`define FRWES_CTRL_ERR 3
`define FRWES_CTRL_PROGRAM_ENABLE 2
`define FRWES_CTRL_GO 1
`define FRWES_ADDR_HIGH_FILL 8'h80

`define FRWES_UNLOCK_KEY1 8'h55
`define FRWES_UNLOCK_KEY2 8'haa
`define FRWES_LATCH_BLANK 14'h3fff
`define FRWES_NUM_LATCHES 32
`define FRWES_ADDR_W 15
`define FRWES_DATA_W 14
`define FRWES_ROW_W 10
`define FRWES_IDX_W 5

`define FRWES_CLK_PERIOD_NS 10
`define FRWES_SETUP_CYCLES 32'h2
`define FRWES_OP_TIME_NS 2000000

`define FRWES_RESP_OKAY 2'h0
`define FRWES_RESP_SLVERR 2'h2

`endif

// File: hdl/frwes_pkg.sv
// Types shared by the flash sequencer modules.
`include "frwes_cfg.svh"

package frwes_pkg;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETUP, SEQ_BUSY} frwes_seq_t;
    typedef enum logic [1:0] {OP_LATCH, OP_ERASE, OP_PROGRAM} frwes_op_t;
    typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_ARMED} frwes_unlock_t;

    typedef struct packed {
        logic [`FRWES_NUM_LATCHES-1:0][`FRWES_DATA_W-1:0] word;
    } frwes_latch_state_t;

    typedef struct packed {
        logic awHave;
        logic awMapped;
        logic [2:0] awIdx;
        logic wHave;
        logic [7:0] wData;
        logic wLane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arHave;
        logic arMapped;
        logic [2:0] arIdx;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic regWr;
        logic [2:0] regIdx;
        logic [7:0] regData;
        logic rdPulse;
    } frwes_axi_state_t;

    typedef struct packed {
        logic [`FRWES_ADDR_W-1:0] addr;
        logic [`FRWES_DATA_W-1:0] data;
        logic config_space_select;
        logic latch_only;
        logic eraseSel;
        logic errFlag;
        logic program_enable;
        logic go;
        frwes_unlock_t unlock;
        frwes_seq_t seq;
        frwes_op_t op;
        logic [31:0] count;
        logic [`FRWES_ROW_W-1:0] rowAddr;
        logic flashErase;
        logic flashProgram;
        logic cpuStall;
        logic nopForce;
        logic latchLoad;
        logic latchClear;
        logic [`FRWES_IDX_W-1:0] loadIdx;
        logic [`FRWES_DATA_W-1:0] loadData;
        logic abortSync1;
        logic abortSync2;
    } frwes_seq_state_t;

endpackage : frwes_pkg

// File: hdl/frwes_latch_bank.sv
// Word write latches that hold one flash row until it is programmed.
`timescale 1ns/1ps
`default_nettype none

module frwes_latch_bank (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clearAll,
    input wire logic loadEn,
    input wire logic [`FRWES_IDX_W-1:0] loadIdx,
    input wire logic [`FRWES_DATA_W-1:0] loadData,
    output logic [`FRWES_NUM_LATCHES*`FRWES_DATA_W-1:0] latchWords
);

    frwes_pkg::frwes_latch_state_t s;
    frwes_pkg::frwes_latch_state_t next_s;

    always_comb begin
        next_s = s;
        for (int i = 0; i < `FRWES_NUM_LATCHES; i++) begin
            if (clearAll) begin
                next_s.word[i] = `FRWES_LATCH_BLANK;
            end else if (loadEn && (loadIdx == i[`FRWES_IDX_W-1:0])) begin
                next_s.word[i] = loadData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= {`FRWES_NUM_LATCHES{`FRWES_LATCH_BLANK}};
        end else begin
            s <= next_s;
        end
    end

    assign latchWords = s.word;

endmodule : frwes_latch_bank

`default_nettype wire

// File: hdl/frwes_axil_slave.sv
// AXI4-Lite slave that turns bus accesses into register strobes.
`timescale 1ns/1ps
`default_nettype none

module frwes_axil_slave (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic regWr,
    output logic [2:0] regIdx,
    output logic [7:0] regData,
    output logic rdPulse,
    output logic [2:0] rdIdx,
    input wire logic [7:0] rdData
);

    frwes_pkg::frwes_axi_state_t s;
    frwes_pkg::frwes_axi_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.regWr = 1'b0;
        next_s.rdPulse = 1'b0;
        if (s_axi_awvalid && s.awready) begin
            next_s.awHave = 1'b1;
            next_s.awIdx = s_axi_awaddr[4:2];
            next_s.awMapped = (s_axi_awaddr[31:5] == 27'h0) && (s_axi_awaddr[4:2] < `FRWES_NUM_REGS);
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.wHave = 1'b1;
            next_s.wData = s_axi_wdata[7:0];
            next_s.wLane0 = s_axi_wstrb[0];
        end
        if (s_axi_bready && s.bvalid) begin
            next_s.bvalid = 1'b0;
        end
        if (s.awHave && s.wHave && !s.bvalid) begin
            next_s.awHave = 1'b0;
            next_s.wHave = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = s.awMapped ? `FRWES_RESP_OKAY : `FRWES_RESP_SLVERR;
            next_s.regWr = s.awMapped && s.wLane0;
            next_s.regIdx = s.awIdx;
            next_s.regData = s.wData;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.arHave = 1'b1;
            next_s.arIdx = s_axi_araddr[4:2];
            next_s.arMapped = (s_axi_araddr[31:5] == 27'h0) && (s_axi_araddr[4:2] < `FRWES_NUM_REGS);
        end
        if (s.arHave && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = s.arMapped ? rdData : 8'h0;
            next_s.rresp = s.arMapped ? `FRWES_RESP_OKAY : `FRWES_RESP_SLVERR;
            next_s.rdPulse = s.arMapped;
        end
        if (s_axi_rready && s.rvalid) begin
            next_s.rvalid = 1'b0;
            next_s.arHave = 1'b0;
        end
        next_s.awready = !next_s.awHave && !next_s.bvalid;
        next_s.wready = !next_s.wHave && !next_s.bvalid;
        next_s.arready = !next_s.arHave;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = {24'h0, s.rdata};
    assign regWr = s.regWr;
    assign regIdx = s.regIdx;
    assign regData = s.regData;
    assign rdPulse = s.rdPulse;
    assign rdIdx = s.arIdx;

endmodule : frwes_axil_slave

`default_nettype wire

// File: tb/frwes_sequencer_sva.sv
// Concurrent checks on the ports of the flash sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "frwes_cfg.svh"

module frwes_sequencer_sva #(
    parameter int unsigned OP_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sysResetReq,
    input wire logic cpuStall,
    input wire logic nopForce,
    input wire logic flashErase,
    input wire logic flashProgram,
    input wire logic [`FRWES_ROW_W-1:0] flashRowAddr,
    input wire logic [`FRWES_NUM_LATCHES*`FRWES_DATA_W-1:0] flashRowData
);
    logic opOn;
    logic sawAbort;
    logic [31:0] opCnt;

    assign opOn = flashErase | flashProgram;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            opCnt <= 32'h0;
            sawAbort <= 1'b0;
        end else begin
            opCnt <= opOn ? opCnt + 32'h1 : 32'h0;
            sawAbort <= sysResetReq | (opOn & sawAbort);
        end
    end

    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence goSeen;
        $rose(nopForce);
    endsequence
    sequence setupDone;
        nopForce [*2] ##1 !nopForce;
    endsequence
    sequence loadOnly;
        $rose(cpuStall) ##2 !opOn;
    endsequence

    chk_setup_two: assert property (goSeen |-> setupDone)
        else $error("forced no-op span is not two cycles");
    chk_nop_stalls: assert property (nopForce |-> cpuStall)
        else $error("forced no-op without core stall");
    chk_latch_go: assert property (loadOnly |-> !cpuStall)
        else $error("latch load stalls beyond setup");
    chk_op_length: assert property ($fell(opOn) && !sawAbort |-> opCnt == OP_CYCLES)
        else $error("erase or program length wrong");
    chk_op_stalls: assert property (opOn |-> cpuStall)
        else $error("core runs during erase or program");
    chk_resume_now: assert property ($fell(opOn) |-> !cpuStall && !nopForce)
        else $error("core not resumed at end of operation");
    chk_one_op: assert property (!(flashErase && flashProgram))
        else $error("erase and program at once");
    chk_row_held: assert property (opOn && $past(opOn) |->
        $stable(flashRowAddr) && $stable(flashRowData))
        else $error("row or latch data moved during operation");
    chk_blank_after: assert property ($fell(opOn) && !sawAbort |=>
        flashRowData == {`FRWES_NUM_LATCHES{`FRWES_LATCH_BLANK}})
        else $error("latches not blank after operation");
endmodule : frwes_sequencer_sva

bind frwes_sequencer frwes_sequencer_sva #(.OP_CYCLES(OP_CYCLES)) u_sva (.clk, .rstn,
    .sysResetReq, .cpuStall, .nopForce, .flashErase, .flashProgram, .flashRowAddr,
    .flashRowData);

`default_nettype wire

// File: tb/frwes_core_model.sv
// Processor core model that measures halts and forced no-ops.
`timescale 1ns/1ps
`default_nettype none

module frwes_core_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cpuStall,
    input wire logic nopForce,
    output logic [31:0] stallLen,
    output logic [31:0] nopLen
);
    logic [31:0] sCnt;
    logic [31:0] nCnt;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sCnt <= 32'h0;
            nCnt <= 32'h0;
            stallLen <= 32'h0;
            nopLen <= 32'h0;
        end else begin
            sCnt <= cpuStall ? sCnt + 32'h1 : 32'h0;
            if (!cpuStall && sCnt != 32'h0) stallLen <= sCnt;
            nCnt <= nopForce ? nCnt + 32'h1 : 32'h0;
            if (!nopForce && nCnt != 32'h0) nopLen <= nCnt;
        end
    end
endmodule : frwes_core_model

`default_nettype wire

// File: tb/frwes_sequencer_tb.sv
// Self-checking bench for the flash sequencer over its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "frwes_cfg.svh"

module frwes_sequencer_tb;
    localparam int unsigned OP = 20;
    localparam logic [4:0] ADL = {`FRWES_OFF_ADDR_LOW, 2'b00};
    localparam logic [4:0] ADH = {`FRWES_OFF_ADDR_HIGH, 2'b00};
    localparam logic [4:0] DTL = {`FRWES_OFF_DATA_LOW, 2'b00};
    localparam logic [4:0] DTH = {`FRWES_OFF_DATA_HIGH, 2'b00};
    localparam logic [4:0] CTL = {`FRWES_OFF_CONTROL, 2'b00};
    localparam logic [4:0] UNL = {`FRWES_OFF_UNLOCK, 2'b00};
    localparam logic [447:0] BLANK = {`FRWES_NUM_LATCHES{`FRWES_LATCH_BLANK}};
    logic clk, rstn, sysResetReq, cpuStall, nopForce, flashErase, flashProgram;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, stallLen, nopLen;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, opKind;
    logic [9:0] flashRowAddr, opRow, v;
    logic [447:0] flashRowData, opData, expRow;
    int error_cnt;
    int n_tests;

    frwes_sequencer #(.OP_CYCLES(OP)) dut (.clk, .rstn, .sysResetReq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cpuStall, .nopForce, .flashErase, .flashProgram, .flashRowAddr,
        .flashRowData);
    frwes_core_model core (.clk, .rstn, .cpuStall, .nopForce, .stallLen, .nopLen);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (flashErase | flashProgram) begin
            opKind <= {flashErase, flashProgram};
            opRow <= flashRowAddr;
            opData <= flashRowData;
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic cmp(input logic [447:0] got, input logic [447:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic ta, tw, b;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {27'h0, a, 24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge clk);
            {ta, tw, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (b !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [9:0] r);
        logic ta, b;
        @(posedge clk);
        s_axi_araddr <= {27'h0, a};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge clk);
            {ta, b} = {s_axi_arready, s_axi_rvalid};
            r = {s_axi_rresp, s_axi_rdata[7:0]};
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (b !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic settle();
        @(posedge clk);
        while (cpuStall !== 1'b0) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : settle

    task automatic unlock_go(input logic [7:0] c);
        wr(UNL, `FRWES_UNLOCK_KEY1);
        wr(UNL, `FRWES_UNLOCK_KEY2);
        opKind <= 2'b00;
        wr(CTL, c);
        settle();
    endtask : unlock_go

    task automatic ld(input logic [7:0] a, input logic [13:0] d, input logic [7:0] c);
        wr(ADL, a);
        wr(DTL, d[7:0]);
        wr(DTH, {2'b00, d[13:8]});
        unlock_go(c);
        expRow[14*a[4:0] +: 14] = d;
    endtask : ld

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("BAD %0t watchdog ran out", $time);
        test_done();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        {rstn, sysResetReq, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 99'h0;
        s_axi_wstrb = 4'h1;
        opKind = 2'b00;
        error_cnt = 0;
        n_tests = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(CTL, v);
        cmp(v, 10'h080);
        rd(ADH, v);
        cmp(v, 10'h080);
        cmp(flashRowData, BLANK);
        wr(UNL, 8'h55);
        rd(UNL, v);
        cmp(v, 10'h000);
        rd(5'h18, v);
        cmp(v, {`FRWES_RESP_SLVERR, 8'h00});
        wr(CTL, 8'h24);
        wr(CTL, 8'h26);
        settle();
        rd(CTL, v);
        cmp(v, 10'h0ac);
        wr(CTL, 8'h24);
        wr(UNL, `FRWES_UNLOCK_KEY1);
        wr(DTL, 8'h11);
        wr(UNL, `FRWES_UNLOCK_KEY2);
        wr(CTL, 8'h26);
        settle();
        rd(CTL, v);
        cmp(v, 10'h0ac);
        wr(CTL, 8'h20);
        unlock_go(8'h22);
        rd(CTL, v);
        cmp(v, 10'h0a8);
        cmp(flashRowData, BLANK);
        cmp(opKind, 0);
        wr(CTL, 8'h24);
        wr(ADH, 8'h12);
        expRow = BLANK;
        ld(8'h3e, 14'h2abc, 8'h26);
        cmp(stallLen, 2);
        ld(8'h3f, 14'h0155, 8'h26);
        cmp(flashRowData, expRow);
        cmp(opKind, 0);
        wr(CTL, 8'h04);
        ld(8'h20, 14'h1c3e, 8'h06);
        cmp(opKind, 2'b01);
        cmp(opRow, 10'h091);
        cmp(opData, expRow);
        cmp(stallLen, 2 + OP);
        cmp(nopLen, 2);
        cmp(flashRowData, BLANK);
        rd(CTL, v);
        cmp(v, 10'h084);
        wr(ADL, 8'h55);
        wr(CTL, 8'h14);
        unlock_go(8'h16);
        cmp(opKind, 2'b10);
        cmp(opRow, 10'h092);
        cmp(stallLen, 2 + OP);
        rd(CTL, v);
        cmp(v, 10'h084);
        wr(CTL, 8'h54);
        unlock_go(8'h56);
        cmp(opKind, 0);
        wr(CTL, 8'h14);
        wr(UNL, `FRWES_UNLOCK_KEY1);
        wr(UNL, `FRWES_UNLOCK_KEY2);
        wr(CTL, 8'h16);
        repeat (6) @(posedge clk);
        sysResetReq <= 1'b1;
        repeat (4) @(posedge clk);
        sysResetReq <= 1'b0;
        settle();
        rd(CTL, v);
        cmp(v, 10'h088);
        cmp(flashRowData, BLANK);
        test_done();
    end
endmodule : frwes_sequencer_tb

`default_nettype wire
